// ---- verilog/mpio_pkg.sv ----
package mpio_pkg;

	// ------------------------------------------------------------
	// Bus and register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int MODE_W = 12;
	localparam int LINES = 2;
	localparam logic [ADDR_W-1:0] LINE0_MODE_SELECT_OFS = 16'hb860;
	localparam logic [ADDR_W-1:0] LINE1_MODE_SELECT_OFS = 16'hb864;
	localparam logic [ADDR_W-1:0] LINE0_MODE_ACTIVE_OFS = 16'hb868;
	localparam logic [ADDR_W-1:0] LINE1_MODE_ACTIVE_OFS = 16'hb86c;
	localparam logic [ADDR_W-1:0] ASYNC_LINE_LEVELS_OFS = 16'hb874;

	// ------------------------------------------------------------
	// Line mode codes
	// ------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_OFF = 12'h000;
	localparam logic [MODE_W-1:0] MODE_ASYNC_IN = 12'h001;
	localparam logic [MODE_W-1:0] MODE_ASYNC_OUT = 12'h002;
	localparam logic [MODE_W-1:0] MODE_DIGITAL_IN = 12'h004;
	localparam logic [MODE_W-1:0] MODE_TRIGGER_IN = 12'h010;
	localparam logic [MODE_W-1:0] MODE_TRIGGER_OUT = 12'h020;
	localparam logic [MODE_W-1:0] MODE_OVERRANGE_OUT = 12'h040;
	localparam logic [MODE_W-1:0] MODE_RUN_INDICATOR = 12'h100;
	localparam logic [MODE_W-1:0] MODE_ARM_INDICATOR = 12'h200;
	localparam logic [MODE_W-1:0] MODE_EARLY_TRIGGER_OUT = 12'h400;
	localparam logic [MODE_W-1:0] MODE_EARLY_TRIGGER_OUT_UNARMED = 12'h800;
	localparam logic [MODE_W-1:0] MODE_RESET = MODE_OFF;

	// ------------------------------------------------------------
	// Sample stream layout
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int ADC_BITS = 12;
	localparam int DIG_BIT0 = 14;
	localparam int DIG_BIT1 = 15;

	// Shared selection of the level that a line in a given mode drives
	typedef enum logic [2:0] {
		SRC_NONE, SRC_ASYNC, SRC_TRIG, SRC_OVR, SRC_RUN, SRC_ARM, SRC_EARLY, SRC_EARLY_ANY
	} drive_src_t;

	function automatic logic mode_valid(input logic [MODE_W-1:0] m);
		return m inside {MODE_OFF, MODE_ASYNC_IN, MODE_ASYNC_OUT, MODE_DIGITAL_IN,
			MODE_TRIGGER_IN, MODE_TRIGGER_OUT, MODE_OVERRANGE_OUT, MODE_RUN_INDICATOR,
			MODE_ARM_INDICATOR, MODE_EARLY_TRIGGER_OUT, MODE_EARLY_TRIGGER_OUT_UNARMED};
	endfunction

	function automatic logic mode_reads_input(input logic [MODE_W-1:0] m);
		return m inside {MODE_ASYNC_IN, MODE_TRIGGER_IN, MODE_DIGITAL_IN};
	endfunction

endpackage

// ---- verilog/sync2.sv ----
`timescale 1ns/10ps
// Two-stage synchroniser; first stage feeds only the second
module sync2 import mpio_pkg::*; #(
	parameter int W = LINES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// Metastability guard
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ---- verilog/line_driver.sv ----
`timescale 1ns/10ps
// Per-line output stage: picks one status level by active mode
module line_driver import mpio_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [MODE_W-1:0] mode,
	input wire logic async_level,
	input wire logic trig_level,
	input wire logic ovr_level,
	input wire logic run_level,
	input wire logic arm_level,
	input wire logic early_level,
	input wire logic early_any_level,
	output logic line_out,
	output logic line_oe
);
	drive_src_t src;

	// Mode decode to a drive source
	always_comb begin
		unique case (mode)
			MODE_ASYNC_OUT: src = SRC_ASYNC;
			MODE_TRIGGER_OUT: src = SRC_TRIG;
			MODE_OVERRANGE_OUT: src = SRC_OVR;
			MODE_RUN_INDICATOR: src = SRC_RUN;
			MODE_ARM_INDICATOR: src = SRC_ARM;
			MODE_EARLY_TRIGGER_OUT: src = SRC_EARLY;
			MODE_EARLY_TRIGGER_OUT_UNARMED: src = SRC_EARLY_ANY;
			default: src = SRC_NONE;
		endcase
	end

	// Registered pin drive; off and input modes leave the pin floating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_out <= 1'b0;
			line_oe <= 1'b0;
		end else begin
			line_oe <= (src != SRC_NONE);
			unique case (src)
				SRC_ASYNC: line_out <= async_level;
				SRC_TRIG: line_out <= trig_level;
				SRC_OVR: line_out <= ovr_level;
				SRC_RUN: line_out <= run_level;
				SRC_ARM: line_out <= arm_level;
				SRC_EARLY: line_out <= early_level;
				SRC_EARLY_ANY: line_out <= early_any_level;
				SRC_NONE: line_out <= 1'b0;
			endcase
		end
	end
endmodule

// ---- verilog/mpio_lines.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/10ps
//
// Operation
// - Each line holds one mode; off tristates the pin and is the reset mode.
// - Code 1 is async input, code 2 async output, both via level register.
// - Digital input puts line0 and line1 levels into sample bits 14 and 15.
// - Any line in digital input mode stops sign extension of samples.
// - Trigger input: line0 feeds ext trigger source 1, line1 source 2.
// - Trigger output: high from trigger detection until post counter reaches zero.
// - In FIFO acquisition, trigger output stays high until FIFO mode stops.
// - Overrange output follows channel 0 on line0, channel 1 on line1.
// - Run indicator is high while acquisition runs, low when stopped.
// - Arm indicator high only while armed and waiting for trigger.
// - Early trigger output rises on a qualifying event when armed, to counter zero.
// - Unarmed early trigger output behaves likewise without checking armed state.
// - Written modes apply only at the next start or setup commit command.
// - Level register bit 0 is line0, bit 1 is line1.
// - Level register reads and writes act on the lines at once.
// - Reading a line driven as output returns its present driven level.
// - Trigger and digital input modes also report input level on read.
//
module mpio_lines import mpio_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_start_cmd,
	input wire logic setup_commit_cmd,
	input wire logic acq_running,
	input wire logic acq_armed,
	input wire logic trigger_detected,
	input wire logic postcount_zero,
	input wire logic fifo_mode,
	input wire logic fifo_stop,
	input wire logic early_trigger_event,
	input wire logic [LINES-1:0] overrange,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic sample_in_valid,
	input wire logic [LINES-1:0] line_in,
	output logic [LINES-1:0] line_out,
	output logic [LINES-1:0] line_oe,
	output logic ext_trigger_src1,
	output logic ext_trigger_src2,
	output logic [SAMPLE_W-1:0] sample_out,
	output logic sample_out_valid
);
	// ------------------------------------------------------------
	// Internal state
	// ------------------------------------------------------------
	logic [MODE_W-1:0] pend_mode_reg [LINES];
	logic [MODE_W-1:0] act_mode_reg [LINES];
	logic [LINES-1:0] async_out_reg;
	logic [LINES-1:0] line_sync;
	logic [LINES-1:0] digin_act;
	logic [LINES-1:0] trigin_act;
	logic [LINES-1:0] level_read;
	logic trig_hold_reg;
	logic early_hold_reg;
	logic early_any_reg;
	logic arm_level;
	logic commit;
	logic setup_phase;
	logic wr_take;
	logic [DATA_W-1:0] rdata_next;
	logic err_next;

	assign commit = card_start_cmd | setup_commit_cmd;
	assign setup_phase = psel & ~penable;
	assign wr_take = psel & penable & pready & pwrite;

	// ------------------------------------------------------------
	// Input synchroniser
	// ------------------------------------------------------------
	sync2 #(.W(LINES)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(line_in),
		.q(line_sync)
	);

	// ------------------------------------------------------------
	// Mode registers
	// ------------------------------------------------------------
	// Pending modes; illegal codes are refused with pslverr and not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LINES; i++) begin
				pend_mode_reg[i] <= MODE_RESET;
			end
		end else if (wr_take && !pslverr) begin
			if (paddr == LINE0_MODE_SELECT_OFS) begin
				pend_mode_reg[0] <= pwdata[MODE_W-1:0];
			end
			if (paddr == LINE1_MODE_SELECT_OFS) begin
				pend_mode_reg[1] <= pwdata[MODE_W-1:0];
			end
		end
	end

	// Active modes move only on a start or commit; a same-cycle write waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LINES; i++) begin
				act_mode_reg[i] <= MODE_RESET;
			end
		end else if (commit) begin
			for (int i = 0; i < LINES; i++) begin
				act_mode_reg[i] <= pend_mode_reg[i];
			end
		end
	end

	// Per-line mode flags used by several paths
	generate
		for (genvar g = 0; g < LINES; g++) begin : g_flag
			assign digin_act[g] = (act_mode_reg[g] == MODE_DIGITAL_IN);
			assign trigin_act[g] = (act_mode_reg[g] == MODE_TRIGGER_IN);
			// Output lines read back the pin drive, input lines the synced pin
			assign level_read[g] = line_oe[g] ? line_out[g] :
				(mode_reads_input(act_mode_reg[g]) & line_sync[g]);
		end
	endgenerate

	// ------------------------------------------------------------
	// Asynchronous level register
	// ------------------------------------------------------------
	// Written straight through, no tie to sampling; bit i is line i
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_out_reg <= '0;
		end else if (wr_take && paddr == ASYNC_LINE_LEVELS_OFS) begin
			async_out_reg <= pwdata[LINES-1:0];
		end
	end

	// ------------------------------------------------------------
	// Trigger-related levels
	// ------------------------------------------------------------
	// Set wins over clear: a new trigger in the zero cycle keeps it high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_hold_reg <= 1'b0;
		end else if (trigger_detected) begin
			trig_hold_reg <= 1'b1;
		end else if (fifo_mode ? fifo_stop : postcount_zero) begin
			trig_hold_reg <= 1'b0;
		end
	end

	// Early output, armed-qualified
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			early_hold_reg <= 1'b0;
		end else if (early_trigger_event && acq_armed) begin
			early_hold_reg <= 1'b1;
		end else if (postcount_zero) begin
			early_hold_reg <= 1'b0;
		end
	end

	// Early output without the arm check; may flag events that never record
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			early_any_reg <= 1'b0;
		end else if (early_trigger_event) begin
			early_any_reg <= 1'b1;
		end else if (postcount_zero) begin
			early_any_reg <= 1'b0;
		end
	end

	// Armed means running, past pretrigger and no trigger seen yet
	assign arm_level = acq_running & acq_armed & ~trig_hold_reg;

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	generate
		for (genvar g = 0; g < LINES; g++) begin : g_line
			line_driver u_drv (
				.pclk(pclk),
				.presetn(presetn),
				.mode(act_mode_reg[g]),
				.async_level(async_out_reg[g]),
				.trig_level(trig_hold_reg),
				.ovr_level(overrange[g]),
				.run_level(acq_running),
				.arm_level(arm_level),
				.early_level(early_hold_reg),
				.early_any_level(early_any_reg),
				.line_out(line_out[g]),
				.line_oe(line_oe[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Extra trigger sources
	// ------------------------------------------------------------
	// Gating by the trigger masks happens downstream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_trigger_src1 <= 1'b0;
			ext_trigger_src2 <= 1'b0;
		end else begin
			ext_trigger_src1 <= trigin_act[0] & line_sync[0];
			ext_trigger_src2 <= trigin_act[1] & line_sync[1];
		end
	end

	// ------------------------------------------------------------
	// Sample stream merge
	// ------------------------------------------------------------
	// Bits above the converter width carry sign unless a digital line is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_out <= '0;
			sample_out_valid <= 1'b0;
		end else begin
			sample_out_valid <= sample_in_valid;
			if (sample_in_valid) begin
				if (|digin_act) begin
					sample_out <= SAMPLE_W'(sample_in[ADC_BITS-1:0]);
					sample_out[DIG_BIT0] <= digin_act[0] & line_sync[0];
					sample_out[DIG_BIT1] <= digin_act[1] & line_sync[1];
				end else begin
					sample_out <= {{(SAMPLE_W-ADC_BITS){sample_in[ADC_BITS-1]}},
						sample_in[ADC_BITS-1:0]};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Read mux and decode; unmapped or illegal mode writes give pslverr
	always_comb begin
		rdata_next = '0;
		err_next = 1'b0;
		unique case (paddr)
			LINE0_MODE_SELECT_OFS: begin
				rdata_next[MODE_W-1:0] = pend_mode_reg[0];
				err_next = pwrite & ~mode_valid(pwdata[MODE_W-1:0]);
			end
			LINE1_MODE_SELECT_OFS: begin
				rdata_next[MODE_W-1:0] = pend_mode_reg[1];
				err_next = pwrite & ~mode_valid(pwdata[MODE_W-1:0]);
			end
			LINE0_MODE_ACTIVE_OFS: begin
				rdata_next[MODE_W-1:0] = act_mode_reg[0];
				err_next = pwrite;
			end
			LINE1_MODE_ACTIVE_OFS: begin
				rdata_next[MODE_W-1:0] = act_mode_reg[1];
				err_next = pwrite;
			end
			ASYNC_LINE_LEVELS_OFS: begin
				rdata_next[LINES-1:0] = level_read;
			end
			default: begin
				err_next = 1'b1;
			end
		endcase
	end

	// One access cycle per transfer; answer registered at the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase & err_next;
			if (setup_phase) begin
				prdata <= pwrite ? '0 : rdata_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_off_tristate;
		@(posedge pclk) disable iff (!presetn)
		(act_mode_reg[0] == MODE_OFF) |=> !line_oe[0];
	endproperty
	a_off_tristate: assert property (p_off_tristate) else $error("line0 driven while off");

	property p_mode_hold;
		@(posedge pclk) disable iff (!presetn)
		!commit |=> $stable(act_mode_reg[0]) && $stable(act_mode_reg[1]);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed without commit");

	property p_async_drive;
		@(posedge pclk) disable iff (!presetn)
		(act_mode_reg[1] == MODE_ASYNC_OUT) ##1 (act_mode_reg[1] == MODE_ASYNC_OUT)
			|-> line_oe[1] && line_out[1] == $past(async_out_reg[1]);
	endproperty
	a_async_drive: assert property (p_async_drive) else $error("async out level wrong");

	property p_digin_bits;
		@(posedge pclk) disable iff (!presetn)
		(sample_in_valid && digin_act[0]) |=> sample_out[DIG_BIT0] == $past(line_sync[0]);
	endproperty
	a_digin_bits: assert property (p_digin_bits) else $error("digital bit 14 wrong");

	property p_no_sign;
		@(posedge pclk) disable iff (!presetn)
		(sample_in_valid && digin_act == 2'b01) |=> sample_out[DIG_BIT0-1:ADC_BITS] == '0;
	endproperty
	a_no_sign: assert property (p_no_sign) else $error("sign extension with digital input");

	property p_trigin;
		@(posedge pclk) disable iff (!presetn)
		!trigin_act[1] |=> !ext_trigger_src2;
	endproperty
	a_trigin: assert property (p_trigin) else $error("src2 active outside trigger input");

	property p_trig_clear;
		@(posedge pclk) disable iff (!presetn)
		(postcount_zero && !fifo_mode && !trigger_detected) |=> !trig_hold_reg;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger out not cleared");

	property p_fifo_hold;
		@(posedge pclk) disable iff (!presetn)
		(trig_hold_reg && fifo_mode && !fifo_stop) |=> trig_hold_reg;
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("fifo trigger out dropped");

	property p_run_ind;
		@(posedge pclk) disable iff (!presetn)
		(act_mode_reg[0] == MODE_RUN_INDICATOR) ##1 (act_mode_reg[0] == MODE_RUN_INDICATOR)
			|-> line_out[0] == $past(acq_running);
	endproperty
	a_run_ind: assert property (p_run_ind) else $error("run indicator mismatch");

	property p_early_armed;
		@(posedge pclk) disable iff (!presetn)
		(!early_hold_reg && !(early_trigger_event && acq_armed)) |=> !early_hold_reg;
	endproperty
	a_early_armed: assert property (p_early_armed) else $error("early out set while unarmed");

	property p_read_out;
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && !pwrite && paddr == ASYNC_LINE_LEVELS_OFS && line_oe[1])
			|=> prdata[1] == $past(line_out[1]) && pready;
	endproperty
	a_read_out: assert property (p_read_out) else $error("level read of output wrong");
endmodule

// ---- verification/mpio_far_end.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Test equipment wired to the two lines
// ----------------------------------------
module mpio_far_end import mpio_pkg::*; (
	input wire logic pclk,
	input wire logic [LINES-1:0] line_out,
	input wire logic [LINES-1:0] line_oe,
	input wire logic [LINES-1:0] drive_en,
	input wire logic [LINES-1:0] drive_val,
	output logic [LINES-1:0] line_in
);
	logic [LINES-1:0] float_reg = 2'h1;

	// No pull on the pins: a released line wanders so stale values never match
	always_ff @(posedge pclk) begin
		float_reg <= ~float_reg;
	end

	// Wire level from all drivers; the card wins, the bench never drives against it
	assign line_in = (line_oe & line_out) | (~line_oe & drive_en & drive_val)
		| (~line_oe & ~drive_en & float_reg);
endmodule

// ---- verification/multipurpose_io_line_control_test.sv ----
`timescale 1ns/10ps
module multipurpose_io_line_control_test import mpio_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic card_start_cmd = 0, setup_commit_cmd = 0, acq_running = 0, acq_armed = 0;
	logic trigger_detected = 0, postcount_zero = 0, fifo_mode = 0, fifo_stop = 0;
	logic early_trigger_event = 0, sample_in_valid = 0, sample_out_valid, er;
	logic ext_trigger_src1, ext_trigger_src2;
	logic [LINES-1:0] overrange = '0, line_in, line_out, line_oe, drive_en = '0, drive_val = '0;
	logic [SAMPLE_W-1:0] sample_in = '0, sample_out;
	logic [MODE_W-1:0] m0 = MODE_OFF, m1 = MODE_OFF;
	bit trig_l, early_l, early_any_l, async_w;
	int errors, n_checks;
	logic [31:0] v;

	always #12.5 pclk = ~pclk;

	mpio_lines mpio_lines_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .card_start_cmd(card_start_cmd), .setup_commit_cmd(setup_commit_cmd),
		.acq_running(acq_running), .acq_armed(acq_armed), .trigger_detected(trigger_detected),
		.postcount_zero(postcount_zero), .fifo_mode(fifo_mode), .fifo_stop(fifo_stop),
		.early_trigger_event(early_trigger_event), .overrange(overrange), .sample_in(sample_in),
		.sample_in_valid(sample_in_valid), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .ext_trigger_src1(ext_trigger_src1),
		.ext_trigger_src2(ext_trigger_src2), .sample_out(sample_out),
		.sample_out_valid(sample_out_valid));

	mpio_far_end mpio_far_end_i (.pclk(pclk), .line_out(line_out), .line_oe(line_oe),
		.drive_en(drive_en), .drive_val(drive_val), .line_in(line_in));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Enter right after a rising edge; one idle cycle follows so psel is never set twice
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Wait as long as the slave needs; a hang is ended by the watchdog alone
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	task automatic set_modes(input logic [MODE_W-1:0] a, b, input bit start);
		apb(1, LINE0_MODE_SELECT_OFS, 32'(a));
		chk(er, 0);
		apb(1, LINE1_MODE_SELECT_OFS, 32'(b));
		chk(er, 0);
		repeat (3) @(posedge pclk);
		apb(0, LINE0_MODE_ACTIVE_OFS, 0);
		chk(rd, 32'(m0));
		if (start) begin
			card_start_cmd <= 1;
		end else begin
			setup_commit_cmd <= 1;
		end
		@(posedge pclk);
		card_start_cmd <= 0;
		setup_commit_cmd <= 0;
		repeat (3) @(posedge pclk);
		m0 = a;
		m1 = b;
		apb(0, LINE0_MODE_ACTIVE_OFS, 0);
		chk(rd, 32'(m0));
		apb(0, LINE1_MODE_ACTIVE_OFS, 0);
		chk(rd, 32'(m1));
	endtask

	function automatic bit pin_of(input logic [MODE_W-1:0] m, input int i);
		case (m)
			MODE_ASYNC_OUT: return async_w;
			MODE_TRIGGER_OUT: return trig_l;
			MODE_OVERRANGE_OUT: return overrange[i];
			MODE_RUN_INDICATOR: return acq_running;
			MODE_ARM_INDICATOR: return acq_running & acq_armed & !trig_l;
			MODE_EARLY_TRIGGER_OUT: return early_l;
			MODE_EARLY_TRIGGER_OUT_UNARMED: return early_any_l;
			default: return 0;
		endcase
	endfunction

	task automatic check_pins();
		logic [MODE_W-1:0] m;
		bit oe;
		for (int i = 0; i < LINES; i++) begin
			m = i ? m1 : m0;
			oe = !(m inside {MODE_OFF, MODE_ASYNC_IN, MODE_DIGITAL_IN, MODE_TRIGGER_IN});
			chk(line_oe[i], oe);
			if (oe) chk(line_out[i], pin_of(m, i));
		end
	endtask

	// One random status step; pulses last a cycle and are spaced past the rearm time
	task automatic step();
		bit tr, pz, fs, ev, clr;
		v = $urandom;
		tr = v[5] & v[6];
		pz = v[7] & v[8];
		fs = v[9];
		ev = v[10] & !pz;
		acq_running <= v[0];
		acq_armed <= v[1];
		fifo_mode <= v[2];
		overrange <= v[4:3];
		trigger_detected <= tr;
		postcount_zero <= pz;
		fifo_stop <= fs;
		early_trigger_event <= ev;
		@(posedge pclk);
		trigger_detected <= 0;
		postcount_zero <= 0;
		fifo_stop <= 0;
		early_trigger_event <= 0;
		clr = v[2] ? fs : pz;
		trig_l = tr | (trig_l & !clr);
		early_l = (ev & v[1]) | (early_l & !pz);
		early_any_l = ev | (early_any_l & !pz);
		repeat (3) @(posedge pclk);
		check_pins();
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(50));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(line_oe, 0);
		apb(0, LINE0_MODE_ACTIVE_OFS, 0);
		chk(rd, 0);
		apb(0, LINE1_MODE_SELECT_OFS, 0);
		chk(rd, 0);
		apb(0, 16'hb870, 0);
		chk(er, 1);
		chk(rd, 0);
		apb(1, LINE0_MODE_SELECT_OFS, 32'h3);
		chk(er, 1);
		// A refused mode code must leave the pending mode untouched
		apb(0, LINE0_MODE_SELECT_OFS, 0);
		chk(rd, 0);
		apb(1, LINE0_MODE_ACTIVE_OFS, 32'h2);
		chk(er, 1);
		// Async access only after the lines are put in async modes
		drive_en <= 2'h1;
		set_modes(MODE_ASYNC_IN, MODE_ASYNC_OUT, 0);
		for (int k = 0; k < 6; k++) begin
			v = $urandom;
			drive_val <= v[1:0];
			async_w = v[1];
			apb(1, ASYNC_LINE_LEVELS_OFS, {30'h0, v[1], v[2]});
			repeat (3) @(posedge pclk);
			check_pins();
			apb(0, ASYNC_LINE_LEVELS_OFS, 0);
			chk(rd, {30'h0, v[1], v[0]});
		end
		drive_en <= 2'h3;
		set_modes(MODE_TRIGGER_IN, MODE_TRIGGER_IN, 1);
		for (int k = 0; k < 4; k++) begin
			v = $urandom;
			drive_val <= v[1:0];
			repeat (4) @(posedge pclk);
			chk(ext_trigger_src1, v[0]);
			chk(ext_trigger_src2, v[1]);
			apb(0, ASYNC_LINE_LEVELS_OFS, 0);
			chk(rd, {30'h0, v[1:0]});
		end
		for (int p = 0; p < 3; p++) begin
			set_modes(p < 2 ? MODE_DIGITAL_IN : MODE_OFF, p < 1 ? MODE_DIGITAL_IN : MODE_OFF, 0);
			for (int k = 0; k < 4; k++) begin
				v = $urandom;
				drive_val <= v[17:16];
				repeat (3) @(posedge pclk);
				sample_in <= {4'h0, v[11:0]};
				sample_in_valid <= 1;
				@(posedge pclk);
				sample_in_valid <= 0;
				#1 chk(sample_out_valid, 1);
				if (p < 2) chk(sample_out, {p < 1 && v[17], v[16], 2'h0, v[11:0]});
				else chk(sample_out, {{4{v[11]}}, v[11:0]});
				@(posedge pclk);
			end
		end
		drive_en <= 2'h0;
		for (int p = 0; p < 4; p++) begin
			case (p)
				// Run indicator on line0 so its line0 check sees traffic
				0: set_modes(MODE_RUN_INDICATOR, MODE_TRIGGER_OUT, 1);
				1: set_modes(MODE_ARM_INDICATOR, MODE_OVERRANGE_OUT, 0);
				2: set_modes(MODE_EARLY_TRIGGER_OUT, MODE_EARLY_TRIGGER_OUT_UNARMED, 1);
				default: set_modes(MODE_OVERRANGE_OUT, MODE_ASYNC_OUT, 0);
			endcase
			repeat (25) step();
		end
		summarize();
	end

	// Bench watchdog, far beyond the fewer than a thousand cycles the sequence needs
	initial begin
		#(25 * 40000);
		errors++;
		summarize();
	end
endmodule
